//--- common/fcc_pkg.sv
// Package of constants and types for the configuration controller.
package fcc_pkg;
	// Configuration port selections.
	typedef enum logic [2:0] {
		FCC_PORT_MSPI = 3'h0,
		FCC_PORT_PAR8 = 3'h1,
		FCC_PORT_SLAVE_SERIAL_LOAD_MODE = 3'h2,
		FCC_PORT_FLASH = 3'h3,
		FCC_PORT_TAP = 3'h4
	} fcc_port_type;

	// Controller states, one-hot.
	typedef enum logic [5:0] {
		FCC_ST_IDLE = 6'h01,
		FCC_ST_HEADER = 6'h02,
		FCC_ST_LOAD = 6'h04,
		FCC_ST_CHECK = 6'h08,
		FCC_ST_USER = 6'h10,
		FCC_ST_FAIL = 6'h20
	} fcc_state_type;

	// Clock rates in kHz.
	localparam int FCC_SYS_CLK_KHZ = 100000;
	localparam int FCC_POWERUP_CLK_KHZ = 3100;
	localparam int FCC_DEFAULT_CLK_KHZ = 2500;
	localparam int FCC_OSC_KHZ = 130000;

	// Half-period divider counts; a least half period rounds up.
	localparam logic [7:0] FCC_DIV_POWERUP =
		8'((FCC_SYS_CLK_KHZ + 2 * FCC_POWERUP_CLK_KHZ - 1) / (2 * FCC_POWERUP_CLK_KHZ));
	localparam logic [7:0] FCC_DIV_DEFAULT =
		8'((FCC_SYS_CLK_KHZ + 2 * FCC_DEFAULT_CLK_KHZ - 1) / (2 * FCC_DEFAULT_CLK_KHZ));

	// Bitstream layout: header word holds a version and clock select fields.
	localparam int FCC_WORD_BITS = 16;
	localparam int FCC_VER_LSB = 0;
	localparam int FCC_VER_BITS = 8;
	localparam int FCC_CLKSEL_LSB = 8;
	localparam int FCC_CLKSEL_BITS = 7;
	localparam int FCC_CLKVALID_BIT = 15;
	localparam logic [15:0] FCC_CRC_INIT = 16'hFFFF;
	localparam logic [15:0] FCC_CRC_POLY = 16'h1021;
	localparam logic [15:0] FCC_SED_WORDS = 16'h0100;
	localparam logic [15:0] FCC_ZERO16 = 16'h0000;

	// Slave SPI command codes.
	localparam logic [7:0] FCC_SPI_READ_STATUS = 8'h05;
	localparam logic [7:0] FCC_SPI_WRITE = 8'h02;
endpackage

//--- design/fcc_top.sv
// Configuration controller: port select, CRC, dual boot, freeze, background check and master clock.
`timescale 1ns/1ps

module fcc_top #(
	parameter int SCAN_LEN = 8,
	parameter logic [7:0] MIN_VERSION = 8'h01,
	parameter logic [23:0] GOLDEN_ADDR = 24'h00_0000,
	parameter logic [23:0] UPDATE_ADDR = 24'h10_0000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire fcc_pkg::fcc_port_type port_select,
	input wire logic boot_update,
	input wire logic freeze_enable,
	input wire logic soft_error_check_enable,
	input wire logic soft_error_flag_enable,
	input wire logic soft_error_inject,
	input wire logic par_strobe,
	input wire logic [7:0] par_data,
	input wire logic flash_strobe,
	input wire logic [7:0] flash_data,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	output logic mspi_sck,
	output logic mspi_cs_n,
	output logic mspi_mosi,
	input wire logic mspi_miso,
	output logic [23:0] boot_addr,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	input wire logic [SCAN_LEN-1:0] scan_capture,
	output logic [SCAN_LEN-1:0] scan_update,
	input wire logic osc_clk_in,
	output logic user_osc_clk,
	output logic config_master_clock,
	output logic user_master_clock,
	output logic io_freeze,
	output logic config_done,
	output logic config_error,
	output logic golden_loaded,
	output logic soft_error
);
	import fcc_pkg::*;

	typedef struct packed {
		fcc_state_type state;
		fcc_port_type port;
		logic [2:0] sck_s;
		logic [1:0] cs_s;
		logic [1:0] mosi_s;
		logic [1:0] miso_s;
		logic [2:0] tck_s;
		logic [1:0] tms_s;
		logic [1:0] tdi_s;
		logic [2:0] par_s;
		logic [2:0] flash_s;
		logic [3:0] tap_state;
		logic tap_load;
		logic [SCAN_LEN-1:0] scan_sr;
		logic [SCAN_LEN-1:0] scan_out;
		logic tdo_q;
		logic [15:0] shift;
		logic [4:0] bits;
		logic [7:0] byte_cnt;
		logic [15:0] crc;
		logic [15:0] len;
		logic [7:0] spi_cmd;
		logic spi_out;
		logic use_golden;
		logic [7:0] div_load;
		logic [7:0] div_pending;
		logic div_change;
		logic [7:0] div_cnt;
		logic mclk;
		logic mspi_clk;
		logic [15:0] sed_cnt;
		logic [15:0] sed_crc;
		logic [15:0] sed_ref;
		logic sed_err;
		logic freeze;
		logic err;
		logic [7:0] osc_div;
	} fcc_regs_type;

	fcc_regs_type st_reg;
	fcc_regs_type st_next;

	// One CRC-16 step over a single bit, shared by load and background check.
	function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc_bit = {c[14:0], 1'b0} ^ (fb ? FCC_CRC_POLY : FCC_ZERO16);
	endfunction

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = crc_bit(r, d[i]);
		end
		crc_byte = r;
	endfunction

	// Half-period divider count for a clock select code; zero means unselected.
	function automatic logic [7:0] div_of(input logic [6:0] sel);
		div_of = (sel == 7'h00) ? FCC_DIV_DEFAULT : {1'b0, sel};
	endfunction

	logic sck_rise;
	logic tck_rise;
	logic par_rise;
	logic flash_rise;
	logic byte_ok;
	logic [7:0] byte_in;
	logic load_active;
	logic [15:0] sed_sum;

	always_comb begin
		sck_rise = st_reg.sck_s[1] & ~st_reg.sck_s[2];
		tck_rise = st_reg.tck_s[1] & ~st_reg.tck_s[2];
		par_rise = st_reg.par_s[1] & ~st_reg.par_s[2];
		flash_rise = st_reg.flash_s[1] & ~st_reg.flash_s[2];
		sed_sum = FCC_CRC_INIT;
		load_active = st_reg.state inside {FCC_ST_HEADER, FCC_ST_LOAD};
		byte_ok = 1'b0;
		byte_in = st_reg.shift[7:0];
		st_next = st_reg;
		// Serial data and select pins pass two flip-flops, clock and strobe pins three; edge logic reads only the second and third stage.
		st_next.sck_s = {st_reg.sck_s[1:0], spi_sck};
		st_next.cs_s = {st_reg.cs_s[0], spi_cs_n};
		st_next.mosi_s = {st_reg.mosi_s[0], spi_mosi};
		st_next.miso_s = {st_reg.miso_s[0], mspi_miso};
		st_next.tck_s = {st_reg.tck_s[1:0], tck};
		st_next.tms_s = {st_reg.tms_s[0], tms};
		st_next.tdi_s = {st_reg.tdi_s[0], tdi};
		st_next.par_s = {st_reg.par_s[1:0], par_strobe};
		st_next.flash_s = {st_reg.flash_s[1:0], flash_strobe};
		// Master clock divider runs always; divider changes only at the end of a high phase.
		if (st_reg.div_cnt >= st_reg.div_load - 8'h01) begin
			st_next.div_cnt = 8'h00;
			st_next.mclk = ~st_reg.mclk;
			if (st_reg.mclk && st_reg.div_change) begin
				st_next.div_load = st_reg.div_pending;
				st_next.div_change = 1'b0;
			end
			if (st_reg.port == FCC_PORT_MSPI && load_active) begin
				st_next.mspi_clk = ~st_reg.mclk;
				// Sample only after a real pin rise, so a load that starts mid-phase takes no extra bit.
				if (st_reg.mspi_clk) begin
					st_next.shift = {st_reg.shift[14:0], st_reg.miso_s[1]};
					st_next.bits = st_reg.bits + 5'h01;
				end
			end else begin
				st_next.mspi_clk = 1'b0;
			end
		end else begin
			st_next.div_cnt = st_reg.div_cnt + 8'h01;
		end
		st_next.osc_div = st_reg.osc_div + 8'h01;
		// Boundary-scan controller: reduced state walk; a scan register update selects the tap port at the next pass through idle.
		if (tck_rise) begin
			st_next.tdo_q = st_reg.scan_sr[0];
			case (st_reg.tap_state)
				4'h0: st_next.tap_state = st_reg.tms_s[1] ? 4'h0 : 4'h1;
				4'h1: st_next.tap_state = st_reg.tms_s[1] ? 4'h2 : 4'h1;
				4'h2: begin
					st_next.tap_state = st_reg.tms_s[1] ? 4'h5 : 4'h3;
					st_next.scan_sr = scan_capture;
				end
				4'h3: begin
					st_next.scan_sr = {st_reg.tdi_s[1], st_reg.scan_sr[SCAN_LEN-1:1]};
					if (st_reg.tms_s[1]) begin
						st_next.tap_state = 4'h4;
					end
					if (load_active && st_reg.port == FCC_PORT_TAP) begin
						st_next.shift = {st_reg.shift[14:0], st_reg.tdi_s[1]};
						st_next.bits = st_reg.bits + 5'h01;
					end
				end
				4'h4: begin
					st_next.scan_out = st_reg.scan_sr;
					st_next.tap_load = 1'b1;
					st_next.tap_state = st_reg.tms_s[1] ? 4'h0 : 4'h1;
				end
				4'h5: st_next.tap_state = st_reg.tms_s[1] ? 4'h0 : 4'h2;
				default: st_next.tap_state = 4'h0;
			endcase
		end
		// Slave SPI: byte-wise shift; a status read returns the done flag and a write command loads data.
		if (st_reg.cs_s[1]) begin
			st_next.bits = (st_reg.port == FCC_PORT_SLAVE_SERIAL_LOAD_MODE) ? 5'h00 : st_next.bits;
			st_next.spi_cmd = 8'h00;
		end else if (sck_rise && st_reg.port == FCC_PORT_SLAVE_SERIAL_LOAD_MODE) begin
			st_next.shift = {st_reg.shift[14:0], st_reg.mosi_s[1]};
			st_next.bits = st_reg.bits + 5'h01;
			st_next.spi_out = st_reg.spi_cmd == FCC_SPI_READ_STATUS ?
				(st_reg.state == FCC_ST_USER) : 1'b0;
		end
		// Bit-serial ports deliver a byte each eight bits.
		if ((st_reg.port inside {FCC_PORT_MSPI, FCC_PORT_TAP, FCC_PORT_SLAVE_SERIAL_LOAD_MODE}) && st_reg.bits == 5'h08) begin
			st_next.bits = 5'h00;
			if (st_reg.port == FCC_PORT_SLAVE_SERIAL_LOAD_MODE && st_reg.spi_cmd != FCC_SPI_WRITE) begin
				st_next.spi_cmd = st_reg.shift[7:0];
			end else begin
				byte_ok = 1'b1;
			end
		end
		// Parallel and flash ports deliver a byte per strobe; other ports are ignored.
		if (st_reg.port == FCC_PORT_PAR8 && par_rise) begin
			byte_ok = 1'b1;
			byte_in = par_data;
		end
		if (st_reg.port == FCC_PORT_FLASH && flash_rise) begin
			byte_ok = 1'b1;
			byte_in = flash_data;
		end
		if (!load_active) begin
			byte_ok = 1'b0;
		end
		case (st_reg.state)
			FCC_ST_IDLE: begin
				// The configuration memory waits on the strapped port after power-up.
				st_next.port = st_reg.tap_load ? FCC_PORT_TAP : port_select;
				st_next.tap_load = 1'b0;
				st_next.crc = FCC_CRC_INIT;
				st_next.byte_cnt = 8'h00;
				st_next.bits = 5'h00;
				st_next.state = FCC_ST_HEADER;
				st_next.freeze = freeze_enable;
				st_next.err = 1'b0;
			end
			FCC_ST_HEADER: if (byte_ok) begin
				// Header: version, clock select, then a 16-bit length; header bytes enter the CRC.
				st_next.crc = crc_byte(st_reg.crc, byte_in);
				st_next.byte_cnt = st_reg.byte_cnt + 8'h01;
				st_next.len = {st_reg.len[7:0], byte_in};
				if (st_reg.byte_cnt == 8'h00 && byte_in < MIN_VERSION) begin
					st_next.state = FCC_ST_FAIL;
				end
				if (st_reg.byte_cnt == 8'h01) begin
					st_next.div_pending = byte_in[7] ? div_of(byte_in[6:0]) : FCC_DIV_DEFAULT;
					st_next.div_change = 1'b1;
				end
				if (st_reg.byte_cnt == 8'h03) begin
					st_next.state = FCC_ST_LOAD;
				end
			end
			FCC_ST_LOAD: if (byte_ok) begin
				st_next.crc = crc_byte(st_reg.crc, byte_in);
				st_next.len = st_reg.len - 16'h0001;
				if (st_reg.len == 16'h0001) begin
					st_next.state = FCC_ST_CHECK;
				end
			end
			FCC_ST_CHECK: begin
				// Trailing two bytes are the CRC itself, so a clean stream leaves zero.
				if (st_reg.crc == FCC_ZERO16) begin
					st_next.state = FCC_ST_USER;
					st_next.freeze = 1'b0;
					st_next.sed_ref = FCC_ZERO16;
					st_next.sed_cnt = FCC_ZERO16;
					st_next.sed_crc = FCC_CRC_INIT;
				end else begin
					st_next.state = FCC_ST_FAIL;
				end
			end
			FCC_ST_FAIL: begin
				// On the master SPI port a bad update image retries from the golden location; a bad golden, or a bad image on any other port, stops.
				st_next.err = 1'b1;
				if (!st_reg.use_golden && st_reg.port == FCC_PORT_MSPI) begin
					st_next.use_golden = 1'b1;
					st_next.state = FCC_ST_IDLE;
				end
			end
			FCC_ST_USER: begin
				// Background sweep: each pass sets the reference for the next; passes after the first compare.
				if (soft_error_check_enable) begin
					st_next.sed_cnt = st_reg.sed_cnt + 16'h0001;
					sed_sum = crc_bit(st_reg.sed_crc, st_reg.sed_cnt[0] ^ soft_error_inject);
					st_next.sed_crc = sed_sum;
					if (st_reg.sed_cnt == FCC_SED_WORDS - 16'h0001) begin
						st_next.sed_cnt = FCC_ZERO16;
						st_next.sed_crc = FCC_CRC_INIT;
						st_next.sed_ref = sed_sum;
						if (st_reg.sed_ref != FCC_ZERO16 && sed_sum != st_reg.sed_ref) begin
							st_next.sed_err = 1'b1;
						end
					end
				end
				// A reboot request reloads from the update location, with outputs frozen only when freeze_enable is set.
				if (boot_update || st_reg.tap_load) begin
					st_next.use_golden = 1'b0;
					st_next.state = FCC_ST_IDLE;
				end
			end
			default: st_next.state = FCC_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.state <= FCC_ST_IDLE;
			st_reg.port <= FCC_PORT_MSPI;
			st_reg.cs_s <= 2'h3;
			st_reg.div_load <= FCC_DIV_POWERUP;
			st_reg.div_pending <= FCC_DIV_POWERUP;
			st_reg.crc <= FCC_CRC_INIT;
			st_reg.sed_crc <= FCC_CRC_INIT;
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		spi_miso = st_reg.spi_out;
		spi_miso_oe_n = st_reg.cs_s[1] | (st_reg.port != FCC_PORT_SLAVE_SERIAL_LOAD_MODE);
		mspi_sck = st_reg.mspi_clk;
		mspi_cs_n = ~(st_reg.port == FCC_PORT_MSPI && st_reg.state inside {FCC_ST_HEADER, FCC_ST_LOAD});
		mspi_mosi = 1'b0;
		boot_addr = st_reg.use_golden ? GOLDEN_ADDR : UPDATE_ADDR;
		tdo = st_reg.tdo_q;
		scan_update = st_reg.scan_out;
		// The oscillator pin is passed to the clock tree as a clock, not sampled as data.
		user_osc_clk = osc_clk_in;
		config_master_clock = st_reg.mclk;
		user_master_clock = st_reg.mclk & (st_reg.state == FCC_ST_USER);
		io_freeze = st_reg.freeze;
		config_done = st_reg.state == FCC_ST_USER;
		config_error = st_reg.err;
		golden_loaded = st_reg.use_golden;
		soft_error = st_reg.sed_err & soft_error_flag_enable;
	end
endmodule

//--- sim/fcc_prom_model.sv
// Boot memory model that streams the image chosen by the boot address.
`timescale 1ns/1ps
module fcc_prom_model #(
	parameter logic [23:0] GOLD_ADDR = 24'h00_0000
) (
	input wire logic mspi_sck,
	input wire logic mspi_cs_n,
	input wire logic [23:0] boot_addr,
	output logic mspi_miso
);
	logic [7:0] gold[$];
	logic [7:0] upd[$];
	int n = 0;
	function automatic logic bit_at(input int k);
		logic [7:0] b;
		b = 8'h55;
		if (boot_addr == GOLD_ADDR && k / 8 < gold.size()) b = gold[k / 8];
		if (boot_addr != GOLD_ADDR && k / 8 < upd.size()) b = upd[k / 8];
		return b[7 - k % 8];
	endfunction
	// Each select restarts the image, so a reboot reads from its first byte.
	always @(negedge mspi_cs_n) begin
		n = 0;
		mspi_miso = bit_at(0);
	end
	always @(negedge mspi_sck) begin
		if (!mspi_cs_n) begin
			n = n + 1;
			mspi_miso = bit_at(n);
		end
	end
	// A deselected memory floats the line; flipping it keeps a stale bit from passing as data.
	always @(posedge mspi_cs_n) mspi_miso = ~mspi_miso;
	initial mspi_miso = 1'b0;
endmodule

//--- sim/fcc_assertions.sv
// Port checker for the configuration controller.
`timescale 1ns/1ps
module fcc_assertions #(
	parameter logic [23:0] GOLDEN_ADDR = 24'h00_0000,
	parameter logic [23:0] UPDATE_ADDR = 24'h10_0000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic soft_error_flag_enable,
	input wire logic spi_cs_n,
	input wire logic spi_miso_oe_n,
	input wire logic [23:0] boot_addr,
	input wire logic osc_clk_in,
	input wire logic user_osc_clk,
	input wire logic config_master_clock,
	input wire logic user_master_clock,
	input wire logic io_freeze,
	input wire logic config_done,
	input wire logic config_error,
	input wire logic golden_loaded,
	input wire logic soft_error
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	property p_freeze_end;
		$fell(io_freeze) |-> ##[0:2] (config_done || config_error);
	endproperty
	a_freeze_end: assert property (p_freeze_end) else $error("freeze dropped early");
	property p_done_excl;
		!(config_done && config_error);
	endproperty
	a_done_excl: assert property (p_done_excl) else $error("done with error");
	property p_user_mclk;
		user_master_clock == (config_master_clock && config_done);
	endproperty
	a_user_mclk: assert property (p_user_mclk) else $error("user clock gating");
	property p_osc;
		user_osc_clk == osc_clk_in;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator not routed");
	property p_miso_oe;
		spi_cs_n [*3] |-> spi_miso_oe_n;
	endproperty
	a_miso_oe: assert property (p_miso_oe) else $error("miso driven unselected");
	property p_soft_gate;
		!soft_error_flag_enable |-> !soft_error;
	endproperty
	a_soft_gate: assert property (p_soft_gate) else $error("soft error ungated");
	// A half period under three cycles would be a runt pulse to the load logic.
	property p_glitch;
		$changed(config_master_clock) |=> $stable(config_master_clock) [*2];
	endproperty
	a_glitch: assert property (p_glitch) else $error("master clock runt");
	property p_boot_addr;
		boot_addr == GOLDEN_ADDR || boot_addr == UPDATE_ADDR;
	endproperty
	a_boot_addr: assert property (p_boot_addr) else $error("boot address stray");
	c_done: cover property (config_done);
	c_error: cover property (config_error);
	c_golden: cover property (golden_loaded && config_done);
endmodule
bind fcc_top fcc_assertions #(.GOLDEN_ADDR(GOLDEN_ADDR), .UPDATE_ADDR(UPDATE_ADDR)) fcc_assertions_inst (
	.sys_clk, .rst, .soft_error_flag_enable, .spi_cs_n, .spi_miso_oe_n, .boot_addr, .osc_clk_in,
	.user_osc_clk, .config_master_clock, .user_master_clock, .io_freeze, .config_done, .config_error,
	.golden_loaded, .soft_error);

//--- sim/fcc_top_tb_top.sv
// Self-checking bench that loads bitstreams over the parallel, flash, slave SPI and master SPI ports.
`timescale 1ns/1ps
module fcc_top_tb_top;
	import fcc_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, boot_update = 1'b0, freeze_enable = 1'b1;
	fcc_port_type port_select = FCC_PORT_PAR8;
	logic soft_error_check_enable = 1'b0, soft_error_flag_enable = 1'b0, soft_error_inject = 1'b0;
	logic par_strobe = 1'b0, flash_strobe = 1'b0, spi_sck = 1'b0, spi_cs_n = 1'b1, spi_mosi = 1'b0;
	logic [7:0] par_data = 8'h00, flash_data = 8'h00, scan_capture = 8'h00, scan_update;
	logic tck = 1'b0, tms = 1'b1, tdi = 1'b0, osc_clk_in = 1'b0;
	logic spi_miso, spi_miso_oe_n, mspi_sck, mspi_cs_n, mspi_mosi, mspi_miso, tdo, user_osc_clk;
	logic config_master_clock, user_master_clock, io_freeze, config_done, config_error;
	logic golden_loaded, soft_error;
	logic [23:0] boot_addr;
	logic [7:0] bs[$];
	int miscompares = 0, checked = 0;
	fcc_top fcc_top_inst (.*);
	fcc_prom_model fcc_prom_model_inst (.mspi_sck, .mspi_cs_n, .boot_addr, .mspi_miso);
	always #5 sys_clk = ~sys_clk;
	always #3.85 osc_clk_in = ~osc_clk_in;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
		for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? FCC_CRC_POLY : 16'h0000);
		return c;
	endfunction
	// Header, four data bytes and a big-endian check word; bad flips the last bit.
	task automatic mk(input logic [7:0] ver, input logic [7:0] clk, input logic bad);
		logic [15:0] c;
		c = 16'hFFFF;
		bs = '{ver, clk, 8'h00, 8'h06, 8'hA5, 8'h3C, 8'h5A, 8'hC3};
		foreach (bs[i]) c = crc(c, bs[i]);
		bs.push_back(c[15:8]);
		bs.push_back(c[7:0] ^ {7'h00, bad});
	endtask
	task automatic send(input fcc_port_type p, input logic [7:0] b);
		if (p == FCC_PORT_SLAVE_SERIAL_LOAD_MODE) begin
			for (int i = 7; i >= 0; i--) begin
				spi_mosi <= b[i];
				repeat (8) @(posedge sys_clk);
				spi_sck <= 1'b1;
				repeat (8) @(posedge sys_clk);
				spi_sck <= 1'b0;
			end
		end else begin
			par_data <= b;
			flash_data <= b;
			@(posedge sys_clk);
			par_strobe <= (p == FCC_PORT_PAR8);
			flash_strobe <= (p == FCC_PORT_FLASH);
			repeat (4) @(posedge sys_clk);
			par_strobe <= 1'b0;
			flash_strobe <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
	endtask
	task automatic load(input fcc_port_type p);
		foreach (bs[i]) begin
			send(p, bs[i]);
			if (i == 0) chk(io_freeze, freeze_enable);
			if (i == 1) send(p == FCC_PORT_PAR8 ? FCC_PORT_FLASH : FCC_PORT_PAR8, 8'hFF);
		end
	endtask
	task automatic wait_end(input int n, input logic e);
		for (int i = 0; i < n && config_done !== 1'b1 && !(e && config_error === 1'b1); i++) @(posedge sys_clk);
	endtask
	task automatic half_period(input logic [31:0] exp);
		int n = 0;
		for (int i = 0; i < 100 && config_master_clock !== 1'b0; i++) @(posedge sys_clk);
		for (int i = 0; i < 100 && config_master_clock !== 1'b1; i++) @(posedge sys_clk);
		for (; n < 100 && config_master_clock === 1'b1; n++) @(posedge sys_clk);
		chk(n, exp);
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end
	initial begin
		do_reset();
		half_period(FCC_DIV_POWERUP);
		mk(8'h01, 8'h84, 1'b0);
		load(FCC_PORT_PAR8);
		wait_end(100, 1'b1);
		chk(config_done, 1'b1);
		chk(io_freeze, 1'b0);
		half_period(4);
		port_select <= FCC_PORT_FLASH;
		freeze_enable <= 1'b0;
		do_reset();
		mk(8'h01, 8'h00, 1'b1);
		load(FCC_PORT_FLASH);
		wait_end(100, 1'b1);
		chk(config_error, 1'b1);
		port_select <= FCC_PORT_SLAVE_SERIAL_LOAD_MODE;
		do_reset();
		mk(8'h01, 8'h00, 1'b0);
		spi_cs_n <= 1'b0;
		send(FCC_PORT_SLAVE_SERIAL_LOAD_MODE, FCC_SPI_WRITE);
		load(FCC_PORT_SLAVE_SERIAL_LOAD_MODE);
		repeat (8) @(posedge sys_clk);
		spi_cs_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		wait_end(100, 1'b1);
		chk(config_done, 1'b1);
		half_period(FCC_DIV_DEFAULT);
		soft_error_check_enable <= 1'b1;
		// Two clean sweeps set the reference first; the upset must differ from it to be seen.
		repeat (600) @(posedge sys_clk);
		chk(soft_error, 1'b0);
		soft_error_inject <= 1'b1;
		repeat (600) @(posedge sys_clk);
		chk(soft_error, 1'b0);
		soft_error_flag_enable <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(soft_error, 1'b1);
		soft_error_inject <= 1'b0;
		fcc_prom_model_inst.gold = bs;
		mk(8'h00, 8'h00, 1'b0);
		fcc_prom_model_inst.upd = bs;
		port_select <= FCC_PORT_MSPI;
		do_reset();
		wait_end(8000, 1'b0);
		chk(config_done, 1'b1);
		chk(boot_addr, 24'h00_0000);
		boot_update <= 1'b1;
		@(posedge sys_clk);
		boot_update <= 1'b0;
		for (int i = 0; i < 500 && config_done === 1'b1; i++) @(posedge sys_clk);
		chk(boot_addr, 24'h10_0000);
		wait_end(20000, 1'b0);
		chk(config_done, 1'b1);
		chk(golden_loaded, 1'b1);
		chk(boot_addr, 24'h00_0000);
		report_and_stop();
	end
endmodule
